// [hw/rdc_map.svh]
`ifndef RDC_MAP_SVH
`define RDC_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define RDC_ADDR_FIXED 12'h000
`define RDC_ADDR_SOURCE 12'h004
`define RDC_ADDR_LEVEL 12'h008

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define RDC_FIX_EN_BIT 7
`define RDC_FIX_ST_BIT 6
`define RDC_FIX_GAIN_HI 5
`define RDC_FIX_GAIN_LO 4
`define RDC_FIX_WMASK 8'hb0
`define RDC_SRC_EN_BIT 7
`define RDC_SRC_LPS_BIT 6
`define RDC_SRC_OE_BIT 5
`define RDC_SRC_PSS_HI 3
`define RDC_SRC_PSS_LO 2
`define RDC_SRC_NSS_BIT 0
`define RDC_SRC_WMASK 8'hed
`define RDC_LVL_WMASK 8'h1f

// ----------------------------------------------------------------
// Reset values and settle count
// ----------------------------------------------------------------
`define RDC_FIX_RESET 8'h10
`define RDC_SRC_RESET 8'h00
`define RDC_LVL_RESET 8'h00
`define RDC_STABLE_RESET 16'h0000
`define RDC_STABLE_CYCLES 16'd200
`define RDC_RDATA_ZERO 32'h0000_0000
`endif

// [hw/rdc_pkg.sv]
package rdc_pkg;
  typedef enum logic [1:0] {RDC_PSRC_SUPPLY, RDC_PSRC_EXT, RDC_PSRC_FIXED, RDC_PSRC_RSVD} rdc_psrc_t;
  typedef enum logic {RDC_NSRC_GROUND, RDC_NSRC_EXT} rdc_nsrc_t;
  typedef struct packed {
    logic dividerOn;
    logic lowPowerHigh;
    logic pinOutputEnable;
    rdc_psrc_t posSource;
    rdc_nsrc_t negSource;
    logic [4:0] levelCode;
    logic fixedRefOn;
    logic [1:0] fixedRefGain;
  } rdc_analog_ctrl_t;
endpackage

// [hw/rdc_ref_dac_ctrl.sv]
`timescale 1ns/10ps
`include "rdc_map.svh"
module rdc_ref_dac_ctrl import rdc_pkg::*; #(
  parameter int LEVEL_BITS = 5,
  parameter logic [15:0] STABLE_CYCLES = `RDC_STABLE_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output rdc_analog_ctrl_t analogCtrl,
  input wire logic refPinIn,
  output logic refPinDigitalIn,
  output logic refPinDigitalOe_n
);

  // Refuse builds the register layout or the settle count cannot serve
  if (LEVEL_BITS < 1 || LEVEL_BITS > 5) begin : g_bad_level_bits
    $error("LEVEL_BITS must be 1 to 5");
  end
  if (STABLE_CYCLES == 16'h0000) begin : g_bad_stable_cycles
    $error("STABLE_CYCLES must be nonzero");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] fixedCtrl_reg;
  logic [7:0] sourceCtrl_reg;
  logic [7:0] level_reg;
  logic [15:0] stableCnt_reg;
  logic stable_reg;
  logic pinSync1_reg;
  logic pinSync2_reg;
  logic [7:0] levelMask;
  logic access;
  logic hitFixed;
  logic hitSource;
  logic hitLevel;
  logic [7:0] readByte;

  // Narrower builds keep the code at the bottom bits of the same layout
  assign levelMask = `RDC_LVL_WMASK & 8'((9'h001 << LEVEL_BITS) - 9'h001);
  assign access = psel && penable;
  assign hitFixed = paddr == `RDC_ADDR_FIXED;
  assign hitSource = paddr == `RDC_ADDR_SOURCE;
  assign hitLevel = paddr == `RDC_ADDR_LEVEL;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fixedCtrl_reg <= `RDC_FIX_RESET;
    end else if (access && pwrite && hitFixed) begin
      fixedCtrl_reg <= pwdata[7:0] & `RDC_FIX_WMASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sourceCtrl_reg <= `RDC_SRC_RESET;
    end else if (access && pwrite && hitSource) begin
      sourceCtrl_reg <= pwdata[7:0] & `RDC_SRC_WMASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_reg <= `RDC_LVL_RESET;
    end else if (access && pwrite && hitLevel) begin
      level_reg <= pwdata[7:0] & levelMask;
    end
  end

  // ----------------------------------------------------------------
  // Fixed reference settle flag
  // ----------------------------------------------------------------
  // Stands in for the analog settle detector; restarts whenever the reference is off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stableCnt_reg <= `RDC_STABLE_RESET;
      stable_reg <= 1'b0;
    end else if (!fixedCtrl_reg[`RDC_FIX_EN_BIT]) begin
      stableCnt_reg <= `RDC_STABLE_RESET;
      stable_reg <= 1'b0;
    end else if (stableCnt_reg >= STABLE_CYCLES - 16'h0001) begin
      stable_reg <= 1'b1;
    end else begin
      stableCnt_reg <= stableCnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------
  always_comb begin
    readByte = 8'h00;
    if (hitFixed) begin
      readByte = fixedCtrl_reg;
      readByte[`RDC_FIX_ST_BIT] = stable_reg;
    end else if (hitSource) begin
      readByte = sourceCtrl_reg;
    end else if (hitLevel) begin
      readByte = level_reg;
    end
  end

  // Zero-wait slave: ready rises at the edge that ends every setup cycle so the access phase lasts one edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `RDC_RDATA_ZERO;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(hitFixed || hitSource || hitLevel);
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h000000, readByte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analogCtrl <= '0;
    end else begin
      analogCtrl.dividerOn <= sourceCtrl_reg[`RDC_SRC_EN_BIT];
      analogCtrl.lowPowerHigh <= sourceCtrl_reg[`RDC_SRC_LPS_BIT];
      analogCtrl.pinOutputEnable <= sourceCtrl_reg[`RDC_SRC_OE_BIT];
      analogCtrl.posSource <= rdc_psrc_t'(sourceCtrl_reg[`RDC_SRC_PSS_HI:`RDC_SRC_PSS_LO]);
      analogCtrl.negSource <= rdc_nsrc_t'(sourceCtrl_reg[`RDC_SRC_NSS_BIT]);
      analogCtrl.levelCode <= level_reg[4:0];
      analogCtrl.fixedRefOn <= fixedCtrl_reg[`RDC_FIX_EN_BIT];
      analogCtrl.fixedRefGain <= fixedCtrl_reg[`RDC_FIX_GAIN_HI:`RDC_FIX_GAIN_LO];
    end
  end

  // ----------------------------------------------------------------
  // Shared pin digital override
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinSync1_reg <= 1'b0;
      pinSync2_reg <= 1'b0;
    end else begin
      pinSync1_reg <= refPinIn;
      pinSync2_reg <= pinSync1_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      refPinDigitalIn <= 1'b0;
      refPinDigitalOe_n <= 1'b1;
    end else begin
      refPinDigitalIn <= pinSync2_reg && !sourceCtrl_reg[`RDC_SRC_OE_BIT];
      refPinDigitalOe_n <= 1'b1;
    end
  end

endmodule // rdc_ref_dac_ctrl

// [verif/rdc_ref_dac_ctrl_assertions.sv]
`timescale 1ns/10ps
`include "rdc_map.svh"
module rdc_ref_dac_ctrl_assertions import rdc_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rdc_analog_ctrl_t analogCtrl,
  input wire logic refPinIn,
  input wire logic refPinDigitalIn,
  input wire logic refPinDigitalOe_n
);
  // ----------------------------------------
  // Bus and control checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic isMapped = paddr inside {`RDC_ADDR_FIXED, `RDC_ADDR_SOURCE, `RDC_ADDR_LEVEL};
  wire logic acc = psel && penable;
  a_ready_access: assert property (acc |-> pready) else $error("no ready in access");
  a_ready_only_access: assert property (pready |-> acc) else $error("stray ready");
  a_slverr_unmapped: assert property (acc |-> pslverr == !isMapped) else $error("bad slverr");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
  a_level_top_zero: assert property (pready && !pwrite && paddr == `RDC_ADDR_LEVEL |-> prdata[7:5] == 3'h0)
    else $error("level top bits");
  a_level_follows: assert property (pready && pwrite && paddr == `RDC_ADDR_LEVEL |-> ##2
    analogCtrl.levelCode == $past(pwdata[4:0], 2)) else $error("level code");
  a_source_follows: assert property (pready && pwrite && paddr == `RDC_ADDR_SOURCE |-> ##2
    {analogCtrl[13:11], analogCtrl[10:9], analogCtrl[8]} == {$past(pwdata[7:5], 2), $past(pwdata[3:2], 2),
    $past(pwdata[0], 2)}) else $error("source fields");
  a_pin_read_blocked: assert property (analogCtrl.pinOutputEnable [*2] |-> !refPinDigitalIn)
    else $error("pin read");
  a_no_digital_drive: assert property (refPinDigitalOe_n) else $error("pin driven");
  c_level_write: cover property (pready && pwrite && paddr == `RDC_ADDR_LEVEL);
  c_unmapped: cover property (pslverr);
  c_pin_out: cover property (analogCtrl.pinOutputEnable && refPinIn);
endmodule // rdc_ref_dac_ctrl_assertions
bind rdc_ref_dac_ctrl rdc_ref_dac_ctrl_assertions u_chk (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .analogCtrl(analogCtrl), .refPinIn(refPinIn), .refPinDigitalIn(refPinDigitalIn),
  .refPinDigitalOe_n(refPinDigitalOe_n));

// [verif/rdc_ref_dac_ctrl_tb.sv]
`timescale 1ns/10ps
`include "rdc_map.svh"
module rdc_ref_dac_ctrl_tb import rdc_pkg::*; ;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, refPinIn = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, refPinDigitalIn, refPinDigitalOe_n, err;
  logic [7:0] lv [3] = '{8'hff, 8'he0, 8'h15};
  rdc_analog_ctrl_t ac;
  int failures = 0, totalChecks = 0;
  always #25 clk = ~clk;
  // Short settle count keeps the stable flag reachable in a few cycles
  rdc_ref_dac_ctrl #(.LEVEL_BITS(5), .STABLE_CYCLES(16'd4)) DUT (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .analogCtrl(ac), .refPinIn(refPinIn), .refPinDigitalIn(refPinDigitalIn),
    .refPinDigitalOe_n(refPinDigitalOe_n));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    if (failures == 0 && totalChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1;
    refPinIn <= 1;
    @(posedge clk);
    #1 chk(32'(ac[13:2]), 32'h0);
    chk(32'(ac[1:0]), 32'h1);
    xfer(0, `RDC_ADDR_FIXED, 0); chk(rdat, 32'h10);
    xfer(0, `RDC_ADDR_SOURCE, 0); chk(rdat, 32'h0);
    xfer(1, `RDC_ADDR_SOURCE, 8'hff);
    xfer(0, `RDC_ADDR_SOURCE, 0); chk(rdat, 32'hed);
    chk(32'(ac[13:8]), 32'h3f);
    chk(32'(refPinDigitalIn), 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1, `RDC_ADDR_SOURCE, 8'(i << 2));
      xfer(0, `RDC_ADDR_SOURCE, 0); chk(32'(ac[13:8]), 32'(i << 1));
    end
    chk(32'(refPinDigitalIn), 32'h1);
    foreach (lv[i]) begin
      xfer(1, `RDC_ADDR_LEVEL, lv[i]);
      xfer(0, `RDC_ADDR_LEVEL, 0); chk(rdat, 32'(lv[i] & 8'h1f));
      chk(32'(ac.levelCode), 32'(lv[i][4:0]));
    end
    xfer(1, 12'h00c, 8'h5a); chk(32'(err), 32'h1);
    xfer(0, 12'h00c, 0); chk(rdat, 32'h0);
    xfer(1, `RDC_ADDR_FIXED, 8'hff);
    repeat (8) @(posedge clk);
    xfer(0, `RDC_ADDR_FIXED, 0); chk(rdat, 32'hf0);
    chk(32'(ac[2:0]), 32'h7);
    arst_n <= 0;
    @(posedge clk);
    #1 chk(32'(ac[13:2]), 32'h0);
    chk(32'(ac[1:0]), 32'h0);
    @(posedge clk) arst_n <= 1;
    xfer(0, `RDC_ADDR_LEVEL, 0); chk(rdat, 32'h0);
    report_and_stop;
  end
  initial begin
    #100us;
    failures++;
    report_and_stop;
  end
endmodule // rdc_ref_dac_ctrl_tb
